// ===== cia_top.sv
// CPU interrupt acceptance: NMI pin, address match, stack pointer, flag restore.
// Assumes all inputs synchronous to ref_clk_i; CPU events are one-cycle pulses except the in_routine, in_nmi and fast_int levels.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cia_top (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire cia_pkg::cia_axi_req_type axi_req_i,
  output cia_pkg::cia_axi_rsp_type      axi_rsp_o,
  input  wire logic                     nmi_n_i,
  input  wire cia_pkg::cia_cpu_evt_type cpu_evt_i,
  input  wire logic                     fetch_valid_i,
  input  wire logic [23:0]              fetch_addr_i,
  input  wire logic [15:0]              stack_flag_i,
  input  wire logic [15:0]              saved_flag_i,
  output logic                          nmi_req_o,
  output logic                          match_req_o,
  output logic [31:0]                   sp_o,
  output logic [15:0]                   flag_o,
  output logic                          sel_int_stack_o,
  output logic                          read_flag_o,
  output logic                          flag_src_saved_o,
  output logic                          ret_go_o,
  output logic                          irq_o
);
  import cia_pkg::*;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : strb_merge

  // ==========================================================
  // Register bus
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              men_reg;
  logic [23:0]       match_reg;
  logic [31:0]       sp_reg;
  logic [CIA_ST_W-1:0] stat_reg;
  logic [CIA_ST_W-1:0] mask_reg;
  logic              nmi_q_reg;
  logic              nmi_qq_reg;
  logic              nmi_req_reg;
  logic              match_req_reg;
  logic [2:0]        blk_reg;
  logic              need_reg;
  logic [15:0]       flag_reg;
  cia_rst_state_type st_reg;
  cia_rst_state_type st_next;

  wire wr_fire = axi_req_i.awvalid & axi_req_i.wvalid & ~bvalid_reg;
  wire rd_fire = axi_req_i.arvalid & ~rvalid_reg;
  wire [4:0] wa = axi_req_i.awaddr;
  wire [4:0] ra = axi_req_i.araddr;
  wire wr_ctrl  = wr_fire & (wa == CIA_CTRL_OFS);
  wire wr_match = wr_fire & (wa == CIA_MATCH_OFS);
  wire wr_sp    = wr_fire & (wa == CIA_SP_OFS);
  wire wr_stat  = wr_fire & (wa == CIA_STAT_OFS);
  wire wr_mask  = wr_fire & (wa == CIA_MASK_OFS);
  wire wr_ok    = wr_ctrl | wr_match | wr_sp | wr_stat | wr_mask | (wa == CIA_PORT_OFS);

  wire [31:0] ctrl_rd = {30'h0, sp_reg[0], men_reg};
  wire [31:0] port_rd = {26'h0, nmi_n_i, 5'h0};
  wire        rd_ok   = (ra == CIA_CTRL_OFS) | (ra == CIA_MATCH_OFS) | (ra == CIA_SP_OFS)
                      | (ra == CIA_PORT_OFS) | (ra == CIA_STAT_OFS) | (ra == CIA_MASK_OFS);
  wire [31:0] rd_mux  = (ra == CIA_CTRL_OFS)  ? ctrl_rd :
                        (ra == CIA_MATCH_OFS) ? {8'h0, match_reg} :
                        (ra == CIA_SP_OFS)    ? sp_reg :
                        (ra == CIA_PORT_OFS)  ? port_rd :
                        (ra == CIA_STAT_OFS)  ? {29'h0, stat_reg} :
                        (ra == CIA_MASK_OFS)  ? {29'h0, mask_reg} : 32'h00000000;

  wire [31:0] ctrl_w  = strb_merge(32'h0, axi_req_i.wdata, axi_req_i.wstrb);
  wire [31:0] match_w = strb_merge({8'h0, match_reg}, axi_req_i.wdata, axi_req_i.wstrb);
  wire [31:0] sp_w    = strb_merge(sp_reg, axi_req_i.wdata, axi_req_i.wstrb);
  wire [31:0] mask_w  = strb_merge({29'h0, mask_reg}, axi_req_i.wdata, axi_req_i.wstrb);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= CIA_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= CIA_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? CIA_OKAY : CIA_SLVERR;
      end else if (axi_req_i.bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_ok ? CIA_OKAY : CIA_SLVERR;
      end else if (axi_req_i.rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    axi_rsp_o         = '0;
    axi_rsp_o.awready = wr_fire;
    axi_rsp_o.wready  = wr_fire;
    axi_rsp_o.bvalid  = bvalid_reg;
    axi_rsp_o.bresp   = bresp_reg;
    axi_rsp_o.arready = rd_fire;
    axi_rsp_o.rvalid  = rvalid_reg;
    axi_rsp_o.rdata   = rdata_reg;
    axi_rsp_o.rresp   = rresp_reg;
  end

  // ==========================================================
  // Configuration and stack pointer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      men_reg   <= 1'b0;
      match_reg <= 24'h000000;
      sp_reg    <= CIA_SP_RST;
      mask_reg  <= '0;
    end else begin
      if (wr_ctrl) men_reg <= ctrl_w[CIA_CTRL_MEN];
      if (wr_match) match_reg <= match_w[23:0];
      if (wr_sp) sp_reg <= sp_w;
      if (wr_mask) mask_reg <= mask_w[CIA_ST_W-1:0];
    end
  end
  // Used as is, even before software loads it; early NMI may run away
  assign sp_o = sp_reg;
  a_sp_reset_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(rst_i) |-> sp_reg == CIA_SP_RST) else $error("sp not zero after reset");
  a_sp_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_sp |=> sp_o == $past(sp_w)) else $error("sp not taken as written");
  // Odd value is only reported; software keeps it even
  a_sp_odd_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_fire && ra == CIA_CTRL_OFS) |=> rdata_reg[CIA_CTRL_SPODD] == $past(sp_reg[0]))
    else $error("odd flag differs from sp");
  a_port_pin_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_fire && ra == CIA_PORT_OFS) |=> rdata_reg[CIA_PORT_NMIBIT] == $past(nmi_n_i))
    else $error("port read differs from pin");

  // ==========================================================
  // NMI pin: edge detect, no gating except mask_reg on irq_o
  // Two-sample filter rejects glitches; legal pulses are far longer
  wire nmi_fall = nmi_qq_reg & ~nmi_q_reg & ~nmi_n_i;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_q_reg   <= 1'b1;
      nmi_qq_reg  <= 1'b1;
      nmi_req_reg <= 1'b0;
    end else begin
      nmi_q_reg   <= nmi_n_i;
      nmi_qq_reg  <= nmi_q_reg;
      nmi_req_reg <= nmi_fall;
    end
  end
  // First instruction after reset is left unprotected; the source keeps quiet
  assign nmi_req_o = nmi_req_reg;
  // Pin edge is never gated, so every fall must surface
  a_nmi_always_req: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    nmi_fall |=> nmi_req_o ##1 !nmi_req_o) else $error("nmi edge not requested");
  a_nmi_latched: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    nmi_req_o |-> stat_reg[CIA_ST_NMI]) else $error("nmi request not in status");

  // ==========================================================
  // Address match with suppression windows
  wire [2:0] blk_load = cpu_evt_i.clr_req | cpu_evt_i.lower_lvl ? CIA_BLK_ICR :
                        cpu_evt_i.set_iflag ? CIA_BLK_IFLAG :
                        cpu_evt_i.lower_cpu_lvl ? CIA_BLK_CPULVL : 3'h0;
  wire [2:0] blk_dec  = (cpu_evt_i.instr_done && blk_reg != 3'h0) ? blk_reg - 3'h1 : blk_reg;
  wire match_hit  = fetch_valid_i & men_reg & (fetch_addr_i == match_reg);
  wire match_fire = match_hit & (blk_reg == 3'h0) & ~cpu_evt_i.routine_entry;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_reg       <= 3'h0;
      match_req_reg <= 1'b0;
    end else begin
      blk_reg       <= (blk_load > blk_dec) ? blk_load : blk_dec;
      match_req_reg <= match_fire;
    end
  end
  assign match_req_o = match_req_reg;

  a_entry_no_match: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cpu_evt_i.routine_entry |=> !match_req_o) else $error("match at routine entry");
  a_clear_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cpu_evt_i.clr_req || cpu_evt_i.lower_lvl) |=> blk_reg == CIA_BLK_ICR)
    else $error("clear window not seven");
  a_iflag_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cpu_evt_i.set_iflag && blk_dec <= 3'h3 && !cpu_evt_i.clr_req && !cpu_evt_i.lower_lvl)
    |=> blk_reg == CIA_BLK_IFLAG) else $error("iflag window not three");
  a_cpu_lvl_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cpu_evt_i.lower_cpu_lvl && blk_dec <= 3'h3 && !cpu_evt_i.clr_req && !cpu_evt_i.lower_lvl)
    |=> blk_reg == CIA_BLK_CPULVL) else $error("level window not three");
  a_window_blocks: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (blk_reg != 3'h0) |-> ##1 !match_req_o) else $error("match inside window");
  // Each retired instruction spends one slot of the window
  a_window_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cpu_evt_i.instr_done && blk_reg != 3'h0 && blk_load == 3'h0)
    |=> blk_reg == $past(blk_reg) - 3'h1) else $error("window not counted down");
  a_match_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (match_hit && blk_reg == 3'h0 && !cpu_evt_i.routine_entry) |=> match_req_o && stat_reg[1])
    else $error("match not raised");

  // ==========================================================
  // Status, mask and interrupt; a set wins over a clear
  wire [CIA_ST_W-1:0] st_set;
  wire [CIA_ST_W-1:0] st_clr;
  assign st_set[CIA_ST_NMI]   = nmi_fall;
  assign st_set[CIA_ST_MATCH] = match_fire;
  assign st_set[CIA_ST_RALL]  = cpu_evt_i.icr_write & cpu_evt_i.in_nmi;
  assign st_clr = wr_stat ? ctrl_w[CIA_ST_W-1:0] : '0;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) stat_reg <= '0;
    else stat_reg <= (stat_reg & ~st_clr) | st_set;
  end
  assign irq_o = |(stat_reg & mask_reg);

  a_restore_all: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cpu_evt_i.icr_write && cpu_evt_i.in_nmi) |=> stat_reg[CIA_ST_RALL])
    else $error("nmi rewrite not latched");
  a_stat_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (nmi_fall && wr_stat) |=> stat_reg[CIA_ST_NMI]) else $error("clear beat nmi event");
  // Restore-all stays until software clears it
  a_rall_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stat_reg[CIA_ST_RALL] && !st_clr[CIA_ST_RALL]) |=> stat_reg[CIA_ST_RALL])
    else $error("restore-all lost");

  // ==========================================================
  // Flag restore sequence ahead of the return
  wire rall = stat_reg[CIA_ST_RALL];
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      CIA_IDLE: if (cpu_evt_i.ret_req) st_next = (need_reg | rall) ? CIA_SEL : CIA_RET;
      CIA_SEL:  st_next = CIA_READ;
      CIA_READ: st_next = CIA_LOAD;
      CIA_LOAD: st_next = CIA_RET;
      CIA_RET:  st_next = CIA_IDLE;
      default:  st_next = CIA_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg   <= CIA_IDLE;
      need_reg <= 1'b0;
      flag_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      if (cpu_evt_i.icr_write && cpu_evt_i.in_routine) need_reg <= 1'b1;
      else if (st_reg == CIA_RET) need_reg <= 1'b0;
      if (st_reg == CIA_LOAD) flag_reg <= cpu_evt_i.fast_int ? saved_flag_i : stack_flag_i;
    end
  end
  assign sel_int_stack_o  = (st_reg == CIA_SEL);
  assign read_flag_o      = (st_reg == CIA_READ);
  assign flag_src_saved_o = cpu_evt_i.fast_int;
  assign ret_go_o         = (st_reg == CIA_RET);
  assign flag_o           = flag_reg;

  a_restore_need: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_reg == CIA_IDLE && cpu_evt_i.ret_req && need_reg) |=> sel_int_stack_o ##1 read_flag_o)
    else $error("restore skipped");
  // Nothing pending: return goes out at once
  a_restore_skip: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_reg == CIA_IDLE && cpu_evt_i.ret_req && !need_reg && !rall) |=> ret_go_o)
    else $error("plain return delayed");
  a_need_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_reg == CIA_RET && !(cpu_evt_i.icr_write && cpu_evt_i.in_routine)) |=> !need_reg)
    else $error("restore need not cleared");
  a_restore_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sel_int_stack_o |=> read_flag_o ##1 (st_reg == CIA_LOAD) ##1 ret_go_o)
    else $error("restore order broken");
  a_restore_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_reg == CIA_LOAD) |=> flag_o == $past(cpu_evt_i.fast_int ? saved_flag_i : stack_flag_i))
    else $error("flag word not loaded");
  a_flag_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_reg != CIA_LOAD) |=> $stable(flag_o)) else $error("flag changed outside load");
endmodule : cia_top

// ===== cia_pkg.sv
// Constants and carrier types for the CPU interrupt acceptance block.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register master.
package cia_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [4:0] CIA_CTRL_OFS  = 5'h00;
  localparam logic [4:0] CIA_MATCH_OFS = 5'h04;
  localparam logic [4:0] CIA_SP_OFS    = 5'h08;
  localparam logic [4:0] CIA_PORT_OFS  = 5'h0C;
  localparam logic [4:0] CIA_STAT_OFS  = 5'h10;
  localparam logic [4:0] CIA_MASK_OFS  = 5'h14;
  localparam logic [31:0] CIA_SP_RST   = 32'h00000000;
  localparam logic [1:0]  CIA_OKAY     = 2'h0;
  localparam logic [1:0]  CIA_SLVERR   = 2'h2;
  // ==========================================================
  // Field positions
  localparam int CIA_CTRL_MEN    = 0;
  localparam int CIA_CTRL_SPODD  = 1;
  localparam int CIA_PORT_NMIBIT = 5;
  localparam int CIA_ST_NMI      = 0;
  localparam int CIA_ST_MATCH    = 1;
  localparam int CIA_ST_RALL     = 2;
  localparam int CIA_ST_W        = 3;
  // ==========================================================
  // Timing and instruction windows
  localparam int CIA_CLK_NS      = 40;
  localparam int CIA_NMI_MIN_NS  = 300;
  localparam int CIA_NMI_MIN_CYC = 2 + (CIA_NMI_MIN_NS + CIA_CLK_NS - 1) / CIA_CLK_NS;
  localparam logic [2:0] CIA_BLK_ICR    = 3'h7;
  localparam logic [2:0] CIA_BLK_IFLAG  = 3'h3;
  localparam logic [2:0] CIA_BLK_CPULVL = 3'h3;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        awvalid;
    logic [4:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [4:0]  araddr;
    logic        rready;
  } cia_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cia_axi_rsp_type;
  typedef struct packed {
    logic instr_done;
    logic clr_req;
    logic lower_lvl;
    logic set_iflag;
    logic lower_cpu_lvl;
    logic routine_entry;
    logic icr_write;
    logic in_routine;
    logic in_nmi;
    logic ret_req;
    logic fast_int;
  } cia_cpu_evt_type;
  typedef enum logic [2:0] {
    CIA_IDLE = 3'h0,
    CIA_SEL  = 3'h1,
    CIA_READ = 3'h3,
    CIA_LOAD = 3'h2,
    CIA_RET  = 3'h6
  } cia_rst_state_type;
endpackage : cia_pkg

// ===== cia_nmi_src.sv
// NMI source model: drives the active-low NMI pin of the acceptance block.
// Assumes one clock; the pin is driven high whenever the source is idle.
`timescale 1ns/1ps
module cia_nmi_src
  import cia_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       retired_i,
  input  wire logic       go_i,
  input  wire logic [7:0] low_cyc_i,
  output logic            nmi_n_o
);
  localparam logic [7:0] HOLD_C = 8'(CIA_NMI_MIN_CYC);
  logic       armed_reg;
  logic       low_reg;
  logic [7:0] cnt_reg;
  // =========================================
  // Pulse shaping
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      low_reg   <= 1'b0;
      cnt_reg   <= 8'h00;
    end else begin
      if (retired_i) armed_reg <= 1'b1;
      if (cnt_reg > 8'h01) cnt_reg <= cnt_reg - 8'h01;
      else if (cnt_reg == 8'h01) begin
        low_reg <= 1'b0;
        cnt_reg <= low_reg ? HOLD_C : 8'h00;
      end else if (go_i && armed_reg) begin
        low_reg <= 1'b1;
        cnt_reg <= (low_cyc_i > HOLD_C) ? low_cyc_i : HOLD_C;
      end
    end
  end
  // Released pin is driven back to the high level
  assign nmi_n_o = !low_reg;
endmodule : cia_nmi_src

// ===== testbench.sv
// Self-checking bench for the CPU interrupt acceptance block.
// Assumes cia_pkg, cia_top and cia_nmi_src are compiled before it.
`timescale 1ns/1ps
module testbench;
  import cia_pkg::*;
  localparam logic [15:0] STK_F   = 16'hA5C3;
  localparam logic [15:0] SAVED_F = 16'h3C5A;
  localparam logic [23:0] M_ADR = 24'h01F2E4;
  localparam cia_cpu_evt_type RETIRE = cia_cpu_evt_type'(11'h400);
  localparam cia_cpu_evt_type ICRW   = cia_cpu_evt_type'(11'h010);
  localparam cia_cpu_evt_type RETQ   = cia_cpu_evt_type'(11'h002);
  logic            ref_clk_i;
  logic            rst_i;
  cia_axi_req_type req;
  cia_axi_rsp_type rsp;
  cia_cpu_evt_type ev;
  logic            nmi_n;
  logic            fv;
  logic            nmi_req;
  logic            m_req;
  logic [31:0]     sp;
  logic [15:0]     flag;
  logic            sel_istk;
  logic            rd_flag;
  logic            flag_src;
  logic            ret_go;
  logic            irq;
  logic            go;
  logic            s;
  logic [31:0]     d;
  logic [1:0]      rs;
  int              n_mismatch;
  int              samples_checked;
  int              nmi_cnt;
  cia_top i_cia_top (
    .ref_clk_i        (ref_clk_i),
    .rst_i            (rst_i),
    .axi_req_i        (req),
    .axi_rsp_o        (rsp),
    .nmi_n_i          (nmi_n),
    .cpu_evt_i        (ev),
    .fetch_valid_i    (fv),
    .fetch_addr_i     (M_ADR),
    .stack_flag_i     (STK_F),
    .saved_flag_i     (SAVED_F),
    .nmi_req_o        (nmi_req),
    .match_req_o      (m_req),
    .sp_o             (sp),
    .flag_o           (flag),
    .sel_int_stack_o  (sel_istk),
    .read_flag_o      (rd_flag),
    .flag_src_saved_o (flag_src),
    .ret_go_o         (ret_go),
    .irq_o            (irq)
  );
  cia_nmi_src i_cia_nmi_src (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .retired_i (ev.instr_done),
    .go_i      (go),
    .low_cyc_i (8'h0C),
    .nmi_n_o   (nmi_n)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
  // =========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] sn, input logic [31:0] e);
    samples_checked++;
    if (sn !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, sn);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] dd, output logic [1:0] r2);
    logic r;
    @(posedge ref_clk_i);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= dd;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      #1 r = rsp.awready;
      @(posedge ref_clk_i);
    end while (!r);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    do begin
      #1 r = rsp.bvalid;
      r2 = rsp.bresp;
      @(posedge ref_clk_i);
    end while (!r);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] dd, output logic [1:0] r2);
    logic r;
    @(posedge ref_clk_i);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      #1 r = rsp.arready;
      @(posedge ref_clk_i);
    end while (!r);
    req.arvalid <= 1'b0;
    do begin
      #1 r = rsp.rvalid;
      dd = rsp.rdata;
      r2 = rsp.rresp;
      @(posedge ref_clk_i);
    end while (!r);
    req.rready <= 1'b0;
  endtask : rd
  task automatic pulse(input cia_cpu_evt_type m);
    @(posedge ref_clk_i);
    ev <= cia_cpu_evt_type'(ev | m);
    @(posedge ref_clk_i);
    ev <= cia_cpu_evt_type'(ev & ~m);
  endtask : pulse
  task automatic fetch(input logic entry, output logic seen);
    @(posedge ref_clk_i);
    fv <= 1'b1;
    ev.routine_entry <= entry;
    @(posedge ref_clk_i);
    fv <= 1'b0;
    ev.routine_entry <= 1'b0;
    #1 seen = m_req;
  endtask : fetch
  task automatic ret(input logic full, input logic [15:0] f);
    pulse(RETQ);
    #1 chk("sel_int_stack", 32'(sel_istk), 32'(full));
    if (full) begin
      chk("flag_src", 32'(flag_src), 32'(ev.fast_int));
      @(posedge ref_clk_i);
      #1 chk("read_flag", 32'(rd_flag), 32'h1);
      repeat (2) @(posedge ref_clk_i);
      #1 chk("flag_o", 32'(flag), 32'(f));
    end
    chk("ret_go", 32'(ret_go), 32'h1);
  endtask : ret
  // =========================================
  // Scenarios
  task automatic t_reset;
    chk("sp_o", sp, CIA_SP_RST);
    pulse(RETIRE);
    rd(CIA_SP_OFS, d, rs);
    chk("sp reg", d, 32'h0);
    rd(5'h18, d, rs);
    chk("unmapped rd", 32'(rs), 32'(CIA_SLVERR));
    wr(5'h1C, 32'h1, rs);
    chk("unmapped wr", 32'(rs), 32'(CIA_SLVERR));
    $display("test reset done");
  endtask : t_reset
  task automatic t_sp;
    wr(CIA_SP_OFS, 32'h00001235, rs);
    chk("sp_o", sp, 32'h00001235);
    rd(CIA_CTRL_OFS, d, rs);
    chk("odd flag", 32'(d[CIA_CTRL_SPODD]), 32'h1);
    wr(CIA_SP_OFS, 32'h00001234, rs);
    rd(CIA_CTRL_OFS, d, rs);
    chk("odd flag", 32'(d[CIA_CTRL_SPODD]), 32'h0);
    $display("test stack pointer done");
  endtask : t_sp
  task automatic t_nmi;
    int n0;
    n0 = nmi_cnt;
    @(posedge ref_clk_i);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    rd(CIA_PORT_OFS, d, rs);
    chk("pin low", 32'(d[CIA_PORT_NMIBIT]), 32'h0);
    // Covers the whole low plus recovery span of the source
    repeat (30) @(posedge ref_clk_i);
    chk("nmi count", 32'(nmi_cnt - n0), 32'h1);
    rd(CIA_PORT_OFS, d, rs);
    chk("pin high", 32'(d[CIA_PORT_NMIBIT]), 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    wr(CIA_MASK_OFS, 32'h1, rs);
    #1 chk("irq", 32'(irq), 32'h1);
    wr(CIA_STAT_OFS, 32'h1, rs);
    #1 chk("irq cleared", 32'(irq), 32'h0);
    $display("test nmi done");
  endtask : t_nmi
  task automatic t_match;
    int n;
    wr(CIA_MATCH_OFS, 32'(M_ADR), rs);
    wr(CIA_CTRL_OFS, 32'h1, rs);
    fetch(1'b0, s);
    chk("match", 32'(s), 32'h1);
    fetch(1'b1, s);
    chk("match at entry", 32'(s), 32'h0);
    // Shift walks clr_req, lower_lvl, set_iflag, lower_cpu_lvl
    for (int e = 0; e < 4; e++) begin
      n = (e < 2) ? 7 : 3;
      pulse(cia_cpu_evt_type'(11'h200 >> e));
      for (int k = 0; k <= n; k++) begin
        fetch(1'b0, s);
        chk("match window", 32'(s), 32'(k == n));
        if (k < n) pulse(RETIRE);
      end
    end
    wr(CIA_CTRL_OFS, 32'h0, rs);
    fetch(1'b0, s);
    chk("match disabled", 32'(s), 32'h0);
    $display("test match done");
  endtask : t_match
  task automatic t_restore;
    @(posedge ref_clk_i);
    ev.in_routine <= 1'b1;
    pulse(ICRW);
    ret(1'b1, STK_F);
    ret(1'b0, STK_F);
    ev.fast_int <= 1'b1;
    pulse(ICRW);
    ret(1'b1, SAVED_F);
    ev.fast_int <= 1'b0;
    ev.in_nmi <= 1'b1;
    pulse(ICRW);
    ret(1'b1, STK_F);
    ev.in_nmi <= 1'b0;
    ret(1'b1, STK_F);
    rd(CIA_STAT_OFS, d, rs);
    chk("restore all", 32'(d[CIA_ST_RALL]), 32'h1);
    wr(CIA_STAT_OFS, 32'h4, rs);
    ret(1'b0, STK_F);
    $display("test restore done");
  endtask : t_restore
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    nmi_cnt = 0;
    req = '0;
    ev = '0;
    fv = 1'b0;
    go = 1'b0;
    rst_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sp();
    t_nmi();
    t_match();
    t_restore();
    end_of_test();
  end
endmodule : testbench
